// ---- hdl/fpb_pkg.sv ----
/*
 * Shared constants for the flash program controller and boot selector:
 * register offsets, command codes, array geometry, timing and reset values.
 * Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package fpb_pkg;

	// ==========================================================
	// array geometry
	localparam int SECTORS = 8;
	localparam int SECTOR_BYTES = 1024;
	localparam int PAGE_BYTES = 64;
	localparam int MEM_BYTES = SECTORS * SECTOR_BYTES;
	localparam int AW = $clog2(MEM_BYTES);
	localparam int SEC_AW = $clog2(SECTORS);
	localparam int PG_AW = $clog2(PAGE_BYTES);
	localparam int LOADER_BYTES = 512;

	// ==========================================================
	// timing: longest time rounds down to whole cycles
	localparam int OP_TIME_US = 2000;
	localparam int CLK_KHZ = 125000;
	localparam int OP_CYCLES_DEF = OP_TIME_US * CLK_KHZ / 1000;

	// ==========================================================
	// register byte offsets
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_ADDR = 6'h08;
	localparam logic [5:0] OFF_WDATA = 6'h0C;
	localparam logic [5:0] OFF_BUF = 6'h10;
	localparam logic [5:0] OFF_READ = 6'h14;
	localparam logic [5:0] OFF_CRC = 6'h18;
	localparam logic [5:0] OFF_BOOT = 6'h1C;
	localparam logic [5:0] OFF_START = 6'h20;
	localparam logic [5:0] OFF_SEC = 6'h24;

	// ==========================================================
	// command codes written to the control register
	localparam logic [3:0] CMD_PROG_PAGE = 4'h1;
	localparam logic [3:0] CMD_ERASE_PAGE = 4'h2;
	localparam logic [3:0] CMD_ERASE_SECTOR = 4'h3;
	localparam logic [3:0] CMD_ERASE_CHIP = 4'h4;
	localparam logic [3:0] CMD_PROG_BYTE = 4'h5;
	localparam logic [3:0] CMD_CRC_SECTOR = 4'h6;
	localparam logic [3:0] CMD_CRC_ALL = 4'h7;
	localparam logic [3:0] CMD_PROG_CFG = 4'h8;
	localparam logic [3:0] CMD_PROG_BOOT = 4'h9;
	localparam logic [3:0] CMD_PROG_SEC = 4'hA;
	localparam logic [3:0] CMD_ERASE_CFG = 4'hB;

	// ==========================================================
	// data values and reset values
	localparam logic [7:0] ERASED = 8'hFF;
	localparam logic [7:0] SEC_OPEN = 8'h00;
	localparam int SEC_PROT_BIT = 0;
	localparam logic [7:0] BOOT_VEC_RST = 8'h1E;
	localparam logic [7:0] BOOT_STAT_RST = 8'h01;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] START_LO = 8'h00;
	localparam logic [15:0] APP_START = 16'h0000;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

	typedef enum logic [1:0] {ST_IDLE, ST_WORK, ST_WAIT} fpb_state_t;

endpackage

// ---- hdl/fpb_crc32.sv ----
/*
 * Byte-wide reflected CRC-32 update, purely combinational.
 * Assumes the caller holds the running value and inverts at the end.
 */
`timescale 1ns/1ps
module fpb_crc32
(
	// running value and new byte
	input wire logic [31:0] crc,
	input wire logic [7:0] data,
	// updated value
	output logic [31:0] crc_next
);
	import fpb_pkg::*;

	logic [31:0] stage [9];

	assign stage[0] = crc ^ 32'(data);

	// ==========================================================
	// one shift-and-fold per bit, lsb first
	for (genvar g = 0; g < 8; g++)
	begin : g_bit
		assign stage[g + 1] = stage[g][0] ? ((stage[g] >> 1) ^ CRC_POLY) : (stage[g] >> 1);
	end

	assign crc_next = stage[8];
endmodule

// ---- hdl/fpb_flash_ctrl.sv ----
/*
 * Program flash controller with page buffer, erase/program sequencing,
 * CRC content check, sector security and power-up boot start selection.
 * Assumes an Avalon-MM master with waitrequest and a synchronous reset
 * that stands for power-on; array contents themselves are not reset.
 */
`timescale 1ns/1ps
module fpb_flash_ctrl #(
	parameter int OP_CYCLES = fpb_pkg::OP_CYCLES_DEF
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// boot selection
	input wire logic force_isp,
	output logic [15:0] start_addr,
	output logic start_valid,
	output logic [7:0] cfg_latched,
	// sequencer state
	output logic busy
);
	import fpb_pkg::*;

	localparam int TW = $clog2(OP_CYCLES + 1);
	// the chip erase walk must fit inside one operation time
	if (OP_CYCLES <= MEM_BYTES)
	begin : g_chk
		$error("OP_CYCLES must exceed the array size");
	end

	// ==========================================================
	// decode helpers
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
		begin
			be_merge[8 * i +: 8] = be[i] ? nw[8 * i +: 8] : old[8 * i +: 8];
		end
	endfunction
	function automatic logic guarded(input logic [3:0] c);
		guarded = (c == CMD_PROG_PAGE) || (c == CMD_ERASE_PAGE)
			|| (c == CMD_ERASE_SECTOR) || (c == CMD_PROG_BYTE);
	endfunction
	function automatic logic is_crc(input logic [3:0] c);
		is_crc = (c == CMD_CRC_SECTOR) || (c == CMD_CRC_ALL);
	endfunction
	function automatic logic [AW-1:0] span(input logic [3:0] c);
		unique case (c)
			CMD_PROG_PAGE, CMD_ERASE_PAGE: span = AW'(PAGE_BYTES - 1);
			CMD_ERASE_SECTOR, CMD_CRC_SECTOR: span = AW'(SECTOR_BYTES - 1);
			CMD_ERASE_CHIP, CMD_CRC_ALL: span = AW'(MEM_BYTES - 1);
			default: span = '0;
		endcase
	endfunction

	// ==========================================================
	// storage and control state
	logic [7:0] mem_q [MEM_BYTES];
	logic [7:0] buf_q [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] bvld_q;
	logic [7:0] sec_q [SECTORS];
	logic [7:0] cfg_q, bstat_q, bvec_q, cfg_live_q;
	fpb_state_t state_q;
	logic busy_q, fail_q, refused_q, done_q, wait_q, start_vld_q;
	logic [3:0] cmd_q;
	logic [AW-1:0] idx_q, last_q, addr_q;
	logic [TW-1:0] tmr_q;
	logic [31:0] crc_q, crc_res_q, wdata_q, rdata_q;
	logic [15:0] start_q;

	// ==========================================================
	// bus decode, array walk and read mux
	wire req = avs_read | avs_write;
	wire wr_take = avs_write & ~wait_q;
	wire wr_ctrl = wr_take && (avs_address == OFF_CTRL) && avs_byteenable[0];
	wire wr_addr = wr_take && (avs_address == OFF_ADDR);
	wire wr_wdata = wr_take && (avs_address == OFF_WDATA);
	wire wr_buf = wr_take && (avs_address == OFF_BUF) && avs_byteenable[0] && !busy_q;
	wire [3:0] new_cmd = avs_writedata[3:0];
	wire cmd_ok = (new_cmd >= CMD_PROG_PAGE) && (new_cmd <= CMD_ERASE_CFG);
	wire [SEC_AW-1:0] tgt_sec = addr_q[AW-1 -: SEC_AW];
	wire prot = sec_q[tgt_sec][SEC_PROT_BIT];
	wire blocked = wr_ctrl && !busy_q && cmd_ok && guarded(new_cmd) && prot;
	wire refuse = wr_ctrl && (busy_q || !cmd_ok);
	wire accept = wr_ctrl && !busy_q && cmd_ok && !blocked;
	wire [AW-1:0] new_span = span(new_cmd);
	wire in_work = state_q == ST_WORK;
	wire walk_end = in_work && (idx_q == last_q);
	wire crc_cmd = is_crc(cmd_q);
	wire [PG_AW-1:0] pg_off = idx_q[PG_AW-1:0];
	wire erase_cmd = (cmd_q == CMD_ERASE_PAGE) || (cmd_q == CMD_ERASE_SECTOR)
		|| (cmd_q == CMD_ERASE_CHIP);
	wire prog_pg = (cmd_q == CMD_PROG_PAGE) && bvld_q[pg_off];
	wire prog_byte = cmd_q == CMD_PROG_BYTE;
	wire mem_we = in_work && (erase_cmd || prog_pg || prog_byte);
	wire [7:0] mem_wd = erase_cmd ? ERASED : (prog_byte ? wdata_q[7:0] : buf_q[pg_off]);
	wire time_up = (state_q == ST_WAIT) && (tmr_q == TW'(OP_CYCLES - 1));
	wire finish = (walk_end && crc_cmd) || time_up;
	wire special = in_work && (cmd_q >= CMD_PROG_CFG);
	wire [31:0] crc_nx;
	fpb_crc32 u_crc (.crc(crc_q), .data(mem_q[idx_q]), .crc_next(crc_nx));
	wire [31:0] status_w = {28'h0000000, done_q, refused_q, fail_q, busy_q};
	wire [31:0] boot_w = {8'h00, cfg_q, bvec_q, bstat_q};
	wire [31:0] rd_mux =
		(avs_address == OFF_STATUS) ? status_w :
		(avs_address == OFF_ADDR) ? 32'(addr_q) :
		(avs_address == OFF_WDATA) ? wdata_q :
		(avs_address == OFF_READ) ? 32'(mem_q[addr_q]) :
		(avs_address == OFF_CRC) ? crc_res_q :
		(avs_address == OFF_BOOT) ? boot_w :
		(avs_address == OFF_START) ? 32'(start_q) :
		(avs_address == OFF_SEC) ? 32'(sec_q[tgt_sec]) :
		32'h00000000;

	// ==========================================================
	// bus handshake: one wait state, answer on the second edge
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end
		else
		begin
			wait_q <= ~(req & wait_q);
			if (req && wait_q)
				rdata_q <= avs_read ? rd_mux : '0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			addr_q <= '0;
			wdata_q <= '0;
		end
		else
		begin
			if (wr_addr)
				addr_q <= AW'(be_merge(32'(addr_q), avs_writedata, avs_byteenable));
			else if (wr_buf)
				addr_q <= {addr_q[AW-1:PG_AW], addr_q[PG_AW-1:0] + 1'b1};
			if (wr_wdata)
				wdata_q <= be_merge(wdata_q, avs_writedata, avs_byteenable);
		end
	end

	// ==========================================================
	// page buffer; loads wrap inside the page so a stray count cannot spill
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			bvld_q <= '0;
		else if (walk_end && cmd_q == CMD_PROG_PAGE)
			bvld_q <= '0;
		else if (wr_buf)
			bvld_q[addr_q[PG_AW-1:0]] <= 1'b1;
	end
	// buffer and array contents are never reset, as in a non-volatile part
	always_ff @(posedge clk_sys)
	begin
		if (wr_buf)
			buf_q[addr_q[PG_AW-1:0]] <= avs_writedata[7:0];
		if (mem_we)
			mem_q[idx_q] <= mem_wd;
	end

	// ==========================================================
	// special bytes: factory values stand in for a fresh part
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cfg_q <= CFG_RST;
			bstat_q <= BOOT_STAT_RST;
			bvec_q <= BOOT_VEC_RST;
			for (int s = 0; s < SECTORS; s++)
				sec_q[s] <= SEC_OPEN;
		end
		else if (special)
		begin
			unique case (cmd_q)
				CMD_PROG_CFG: cfg_q <= wdata_q[7:0];
				CMD_PROG_BOOT:
				begin
					bstat_q <= wdata_q[7:0];
					bvec_q <= wdata_q[15:8];
				end
				CMD_PROG_SEC: sec_q[last_q[AW-1 -: SEC_AW]] <= wdata_q[7:0];
				default:
				begin
					cfg_q <= ERASED;
					bstat_q <= ERASED;
					bvec_q <= ERASED;
				end
			endcase
		end
		else if (walk_end && cmd_q == CMD_ERASE_CHIP)
		begin
			for (int s = 0; s < SECTORS; s++)
				sec_q[s] <= SEC_OPEN;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
			cmd_q <= '0;
			idx_q <= '0;
			last_q <= '0;
			tmr_q <= '0;
			crc_q <= CRC_INIT;
			crc_res_q <= '0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (accept)
					begin
						state_q <= ST_WORK;
						busy_q <= 1'b1;
						cmd_q <= new_cmd;
						idx_q <= addr_q & ~new_span;
						last_q <= addr_q | new_span;
						tmr_q <= '0;
						crc_q <= CRC_INIT;
					end
				end
				ST_WORK:
				begin
					tmr_q <= tmr_q + 1'b1;
					idx_q <= idx_q + 1'b1;
					if (crc_cmd)
						crc_q <= crc_nx;
					if (walk_end && crc_cmd)
					begin
						state_q <= ST_IDLE;
						busy_q <= 1'b0;
						crc_res_q <= ~crc_nx;
					end
					else if (walk_end)
						state_q <= ST_WAIT;
				end
				ST_WAIT:
				begin
					tmr_q <= tmr_q + 1'b1;
					if (time_up)
					begin
						state_q <= ST_IDLE;
						busy_q <= 1'b0;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// result flags; an accepted command clears them, events set them
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			fail_q <= 1'b0;
			refused_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			fail_q <= blocked | (fail_q & ~accept);
			refused_q <= refuse | (refused_q & ~accept);
			done_q <= finish | (done_q & ~accept);
		end
	end

	// ==========================================================
	// boot start selection, caught once just after reset release
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			start_q <= APP_START;
			start_vld_q <= 1'b0;
			cfg_live_q <= CFG_RST;
		end
		else if (!start_vld_q)
		begin
			start_vld_q <= 1'b1;
			cfg_live_q <= cfg_q;
			start_q <= (bstat_q != 8'h00 || force_isp) ? {bvec_q, START_LO} : APP_START;
		end
	end
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign start_addr = start_q;
	assign start_valid = start_vld_q;
	assign cfg_latched = cfg_live_q;
	assign busy = busy_q;
endmodule

// ---- testbench/fpb_flash_ctrl_checker.sv ----
/*
 * Port-level assertions for the flash controller.
 * Assumes one clock domain; bound to every controller instance.
 */
`timescale 1ns/1ps
module fpb_flash_ctrl_checker #(
	parameter int OP_CYCLES = fpb_pkg::OP_CYCLES_DEF
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// bus
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// boot and state
	input wire logic force_isp,
	input wire logic [15:0] start_addr,
	input wire logic start_valid,
	input wire logic [7:0] cfg_latched,
	input wire logic busy
);
	import fpb_pkg::*;
	// ==========================================================
	// busy length: counted, a repetition would be far too long
	logic [31:0] busy_cnt_q;
	logic [31:0] busy_cnt_d;
	assign busy_cnt_d = busy ? busy_cnt_q + 32'h1 : 32'h0;
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			busy_cnt_q <= 32'h0;
		else
			busy_cnt_q <= busy_cnt_d;
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// assertions
	chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	chk_busy_cause: assert property ($rose(busy) |-> $past(avs_write)
		&& !$past(avs_waitrequest) && $past(avs_address) == OFF_CTRL)
		else $error("busy rose without a control write");
	chk_busy_len: assert property ($fell(busy) |-> busy_cnt_q == OP_CYCLES
		|| busy_cnt_q == SECTOR_BYTES || busy_cnt_q == MEM_BYTES)
		else $error("busy length wrong");
	chk_busy_bound: assert property (busy_cnt_q <= OP_CYCLES)
		else $error("operation too long");
	chk_boot_vec: assert property ($rose(start_valid)
		|-> start_addr == {BOOT_VEC_RST, START_LO})
		else $error("start address wrong after reset");
	chk_cfg_stable: assert property (start_valid |=> $stable(cfg_latched))
		else $error("latched config changed");
	chk_start_hold: assert property (start_valid && $past(start_valid) |-> $stable(start_addr))
		else $error("start address changed");
endmodule
bind fpb_flash_ctrl fpb_flash_ctrl_checker #(.OP_CYCLES(OP_CYCLES)) chk_u (.clk_sys(clk_sys),
	.rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .force_isp(force_isp),
	.start_addr(start_addr), .start_valid(start_valid), .cfg_latched(cfg_latched), .busy(busy));

// ---- testbench/fpb_core_model.sv ----
/*
 * Processor-side bus master model issuing register cycles.
 * Assumes the controller answers with waitrequest on clk_sys.
 */
`timescale 1ns/1ps
module fpb_core_model
(
	// clock
	input wire logic clk_sys,
	// bus master side
	output logic [5:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial
	begin
		avs_address = 6'h3F;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end
	// ==========================================================
	// one cycle, held until waitrequest is seen low
	task automatic xfer(input logic wr_en, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		repeat ($urandom % 3) @(posedge clk_sys);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hF;
		avs_write <= wr_en;
		avs_read <= !wr_en;
		// no limit of its own: only the bench timeout ends a hung wait
		do
		begin
			@(posedge clk_sys);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// released lines must not keep showing the last value
		avs_address <= ~a;
		avs_writedata <= ~d;
		avs_byteenable <= 4'h0;
	endtask
endmodule

// ---- testbench/fpb_flash_ctrl_tb_top.sv ----
/*
 * Self-checking bench for the flash controller with a shadow array.
 * Assumes the core model drives the bus and OP_CYCLES of 9000.
 */
`timescale 1ns/1ps
module fpb_flash_ctrl_tb_top;
	import fpb_pkg::*;
	localparam int OPC = 9000;
	logic clk_sys;
	logic rst_n;
	logic force_isp;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] start_addr;
	logic start_valid;
	logic [7:0] cfg_latched;
	logic busy;
	logic [7:0] shadow [MEM_BYTES];
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	fpb_flash_ctrl #(.OP_CYCLES(OPC)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .force_isp(force_isp),
		.start_addr(start_addr), .start_valid(start_valid), .cfg_latched(cfg_latched),
		.busy(busy));
	fpb_core_model core_u (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	always #4 clk_sys = ~clk_sys;
	// ==========================================================
	// helpers
	task automatic summarize();
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		core_u.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		core_u.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic wt();
		int n;
		n = 0;
		repeat (2) @(posedge clk_sys);
		while (busy === 1'b1 && n < 20000)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 20000)
			errors++;
	endtask
	task automatic op(input logic [3:0] c);
		wr(OFF_CTRL, {28'h0, c});
		wt();
	endtask
	task automatic rdb(input int a);
		logic [31:0] q;
		wr(OFF_ADDR, a);
		rd(OFF_READ, q);
		chk({24'h0, q[7:0]}, {24'h0, shadow[a]}, "flash byte");
	endtask
	// reflected crc over a span of the shadow array
	function automatic logic [31:0] crc_of(input int b, input int len);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < len; i++)
		begin
			c = c ^ {24'h0, shadow[b + i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return ~c;
	endfunction
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			errors++;
			summarize();
		end
	end
	// ==========================================================
	// main sequence
	initial
	begin
		logic [31:0] q;
		int base;
		int n;
		int nb;
		logic [7:0] v;
		logic [7:0] vec;
		clk_sys = 1'b0;
		rst_n = 1'b0;
		force_isp = 1'b0;
		void'($urandom(32'h4E5B));
		repeat (15) @(posedge clk_sys);
		force_isp <= 1'($urandom % 2);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({31'h0, start_valid}, 32'h1, "start valid");
		rd(OFF_START, q);
		chk(q, {16'h0, BOOT_VEC_RST, START_LO}, "start");
		rd(OFF_BOOT, q);
		chk(q, {8'h0, CFG_RST, BOOT_VEC_RST, BOOT_STAT_RST}, "boot bytes");
		rd(6'h3C, q);
		chk(q, 32'h0, "unmapped");
		op(CMD_ERASE_CHIP);
		for (int i = 0; i < MEM_BYTES; i++)
			shadow[i] = ERASED;
		for (int k = 0; k < 4; k++)
			rdb($urandom % MEM_BYTES);
		base = ($urandom % 112) * PAGE_BYTES;
		n = 1 + $urandom % PAGE_BYTES;
		wr(OFF_ADDR, base);
		for (int i = 0; i < n; i++)
		begin
			v = $urandom;
			shadow[base + i] = v;
			wr(OFF_BUF, {24'h0, v});
		end
		wr(OFF_CTRL, {28'h0, CMD_PROG_PAGE});
		wr(OFF_CTRL, {28'h0, CMD_ERASE_PAGE});
		rd(OFF_STATUS, q);
		chk(q & 32'h5, 32'h5, "refused while busy");
		wt();
		rd(OFF_STATUS, q);
		chk(q & 32'hC, 32'hC, "done");
		for (int i = 0; i < PAGE_BYTES; i++)
			rdb(base + i);
		nb = base ^ PAGE_BYTES;
		v = $urandom;
		wr(OFF_ADDR, nb);
		wr(OFF_WDATA, {24'h0, v});
		op(CMD_PROG_BYTE);
		shadow[nb] = v;
		rdb(nb);
		wr(OFF_ADDR, nb);
		op(CMD_CRC_SECTOR);
		rd(OFF_CRC, q);
		chk(q, crc_of(nb & 32'h1C00, SECTOR_BYTES), "crc");
		op(CMD_CRC_ALL);
		rd(OFF_CRC, q);
		chk(q, crc_of(0, MEM_BYTES), "crc all");
		wr(OFF_ADDR, base);
		op(CMD_ERASE_PAGE);
		for (int i = 0; i < PAGE_BYTES; i++)
			shadow[base + i] = ERASED;
		rdb(base + n - 1);
		rdb(nb);
		wr(OFF_ADDR, 32'h1C00);
		wr(OFF_WDATA, 32'h1);
		op(CMD_PROG_SEC);
		rd(OFF_SEC, q);
		chk(q & 32'hFF, 32'h1, "security byte");
		wr(OFF_CTRL, {28'h0, CMD_ERASE_SECTOR});
		rd(OFF_STATUS, q);
		chk(q & 32'h3, 32'h2, "protected erase");
		rdb(32'h1C00 + $urandom % SECTOR_BYTES);
		op(CMD_ERASE_CFG);
		rd(OFF_BOOT, q);
		chk(q, 32'h00FFFFFF, "special erased");
		vec = 8'h1 + 8'($urandom % 255);
		wr(OFF_WDATA, 32'h5A);
		op(CMD_PROG_CFG);
		wr(OFF_WDATA, {16'h0, vec, 8'h00});
		op(CMD_PROG_BOOT);
		rd(OFF_BOOT, q);
		chk(q, {8'h0, 8'h5A, vec, 8'h00}, "special bytes");
		chk({24'h0, cfg_latched}, {24'h0, CFG_RST}, "config latch");
		rd(OFF_START, q);
		chk(q, {16'h0, BOOT_VEC_RST, START_LO}, "start held");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		force_isp <= ~force_isp;
		repeat (4) @(posedge clk_sys);
		chk({31'h0, start_valid}, 32'h0, "valid in reset");
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({16'h0, start_addr}, {16'h0, BOOT_VEC_RST, START_LO}, "start again");
		summarize();
	end
endmodule
